// *** hdl/mtseq_tick.v ***
// microsecond tick divider for the delay timer
`default_nettype none
module mtseq_tick #(
  parameter DIV = 25
) (
  // clock and reset
  input  wire aclk,
  input  wire aresetn,
  // one-cycle enable every DIV clocks
  output reg  tick_ff
);
  reg [7:0] cnt_ff;
  wire      last = (cnt_ff == DIV[7:0] - 8'h01);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= last ? 8'h00 : cnt_ff + 8'h01;
      tick_ff <= last;
    end
  end
endmodule // mtseq_tick
`default_nettype wire

// *** hdl/mtseq_top.v ***
// trigger sequencer with axi4-lite registers
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`include "mtseq_defines.vh"
`default_nettype none
module mtseq_top #(
  parameter CLK_DIV = `MTSEQ_STEP_NS / `MTSEQ_CLK_NS
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // external trigger pin
  input  wire        ext_trig_in,
  // converter handshake
  output reg         meas_start_ff,
  input  wire        meas_done,
  // measurement mode from the function logic
  input  wire        func_cont_diode,
  input  wire [31:0] auto_delay_us,
  // state outputs
  output reg         armed_ff,
  output reg         busy_ff
);
  localparam ST_IDLE  = 5'b00001;
  localparam ST_WAIT  = 5'b00010;
  localparam ST_DELAY = 5'b00100;
  localparam ST_MEAS  = 5'b01000;
  localparam ST_NEXT  = 5'b10000;

  // configuration
  reg [1:0]  src_ff;
  reg        pol_rise_ff;
  reg        auto_ff;
  reg        inf_ff;
  reg [31:0] delay_ff;
  reg [19:0] samples_ff;
  reg [19:0] trigcnt_ff;
  // sequencer
  reg [4:0]  state_ff;
  reg [31:0] dly_cnt_ff;
  reg [19:0] samp_left_ff;
  reg [19:0] trig_done_ff;
  reg        pend_ff;
  reg        bus_trg_ff;
  reg [9:0]  rd_cnt_ff;
  reg        ovfl_ff;
  // axi
  reg        aw_held_ff;
  reg        w_held_ff;
  reg [7:0]  awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0]  wstrb_ff;
  // pin sync
  reg        ext_s1_ff;
  reg        ext_s2_ff;
  reg        ext_s3_ff;

  wire tick;
  mtseq_tick #(
    .DIV     (CLK_DIV)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick_ff (tick)
  );

  // two-stage sync, third stage only for edge compare
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_s1_ff <= 1'b1;
      ext_s2_ff <= 1'b1;
      ext_s3_ff <= 1'b1;
    end
    else
    begin
      ext_s1_ff <= ext_trig_in;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end

  wire ext_edge = pol_rise_ff ? (ext_s2_ff & ~ext_s3_ff)
                              : (~ext_s2_ff & ext_s3_ff);

  // write channel
  wire wr_go = aw_held_ff & w_held_ff & ~s_axi_bvalid;
  wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                       {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire [31:0] wval = wdata_ff & wmask;
  wire wr_ctrl  = wr_go && awaddr_ff == `MTSEQ_OFF_CTRL;
  wire wr_dly   = wr_go && awaddr_ff == `MTSEQ_OFF_DELAY;
  wire wr_samp  = wr_go && awaddr_ff == `MTSEQ_OFF_SAMPLES;
  wire wr_trig  = wr_go && awaddr_ff == `MTSEQ_OFF_TRIGCNT;
  wire wr_cmd   = wr_go && awaddr_ff == `MTSEQ_OFF_COMMAND;
  wire wr_known = wr_ctrl | wr_dly | wr_samp | wr_trig | wr_cmd;
  wire cmd_arm    = wr_cmd & wval[`MTSEQ_CMD_ARM];
  wire cmd_trg    = wr_cmd & wval[`MTSEQ_CMD_TRG];
  wire cmd_abort  = wr_cmd & wval[`MTSEQ_CMD_ABORT];
  wire cmd_preset = wr_cmd & wval[`MTSEQ_CMD_PRESET];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MTSEQ_RESP_OKAY;
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h00000000;
      wstrb_ff      <= 4'h0;
    end
    else
    begin
      s_axi_awready <= ~aw_held_ff & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held_ff & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `MTSEQ_RESP_OKAY : `MTSEQ_RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers
  wire [31:0] dly_clip = (wval > `MTSEQ_DLY_MAX) ? `MTSEQ_DLY_MAX : wval;
  always @(posedge aclk)
  begin
    if (!aresetn || cmd_preset)
    begin
      src_ff      <= `MTSEQ_SRC_IMM;
      pol_rise_ff <= 1'b0;
      auto_ff     <= 1'b1;
      inf_ff      <= 1'b0;
      delay_ff    <= `MTSEQ_DLY_DEFAULT;
      samples_ff  <= `MTSEQ_CNT_DEFAULT;
      trigcnt_ff  <= `MTSEQ_CNT_DEFAULT;
    end
    else
    begin
      if (wr_ctrl)
      begin
        src_ff      <= wval[`MTSEQ_CTRL_SRC_HI:`MTSEQ_CTRL_SRC_LO];
        pol_rise_ff <= wval[`MTSEQ_CTRL_POL];
        auto_ff     <= wval[`MTSEQ_CTRL_AUTO];
        inf_ff      <= wval[`MTSEQ_CTRL_INF];
      end
      if (wr_dly)
      begin
        delay_ff <= dly_clip;
        auto_ff  <= 1'b0;
      end
      if (wr_samp)
        samples_ff <= (wval[19:0] == 20'h00000) ? `MTSEQ_CNT_DEFAULT
                                                : wval[19:0];
      if (wr_trig)
        trigcnt_ff <= (wval[19:0] == 20'h00000) ? `MTSEQ_CNT_DEFAULT :
                      (wval[19:0] > `MTSEQ_TRIG_MAX) ? `MTSEQ_TRIG_MAX :
                      wval[19:0];
    end
  end

  // effective delay in microseconds
  wire [31:0] eff_delay = func_cont_diode ? 32'h00000000 :
                          auto_ff ? auto_delay_us : delay_ff;

  // trigger qualification, only once armed
  wire in_wait  = (state_ff == ST_WAIT);
  wire trig_now = in_wait & (
    (src_ff == `MTSEQ_SRC_IMM) |
    ((src_ff == `MTSEQ_SRC_BUS) & bus_trg_ff) |
    ((src_ff == `MTSEQ_SRC_EXT) & (pend_ff | ext_edge)));
  wire last_trig = ~inf_ff & (trig_done_ff + 20'h00001 >= trigcnt_ff);

  // sequencer
  always @(posedge aclk)
  begin
    if (!aresetn || cmd_abort || cmd_preset)
    begin
      state_ff      <= ST_IDLE;
      dly_cnt_ff    <= 32'h00000000;
      samp_left_ff  <= 20'h00000;
      trig_done_ff  <= 20'h00000;
      pend_ff       <= 1'b0;
      bus_trg_ff    <= 1'b0;
      meas_start_ff <= 1'b0;
      armed_ff      <= 1'b0;
      busy_ff       <= 1'b0;
    end
    else
    begin
      meas_start_ff <= 1'b0;
      // bus trigger ignored unless armed and waiting
      bus_trg_ff <= cmd_trg & in_wait & ~trig_now;
      // one held external edge while busy
      if (trig_now)
        pend_ff <= 1'b0;
      else if (ext_edge & (src_ff == `MTSEQ_SRC_EXT) & armed_ff & ~in_wait)
        pend_ff <= 1'b1;
      case (state_ff)
        ST_IDLE:
        begin
          busy_ff <= 1'b0;
          if (cmd_arm)
          begin
            state_ff     <= ST_WAIT;
            armed_ff     <= 1'b1;
            trig_done_ff <= 20'h00000;
          end
        end
        ST_WAIT:
        begin
          if (trig_now)
          begin
            state_ff     <= ST_DELAY;
            busy_ff      <= 1'b1;
            samp_left_ff <= samples_ff;
            dly_cnt_ff   <= eff_delay;
          end
        end
        ST_DELAY:
        begin
          if (dly_cnt_ff == 32'h00000000)
          begin
            meas_start_ff <= 1'b1;
            state_ff      <= ST_MEAS;
          end
          else if (tick)
            dly_cnt_ff <= dly_cnt_ff - 32'h00000001;
        end
        ST_MEAS:
        begin
          if (meas_done)
          begin
            samp_left_ff <= samp_left_ff - 20'h00001;
            state_ff     <= ST_NEXT;
          end
        end
        ST_NEXT:
        begin
          if (samp_left_ff != 20'h00000)
          begin
            dly_cnt_ff <= eff_delay;
            state_ff   <= ST_DELAY;
          end
          else
          begin
            busy_ff      <= 1'b0;
            trig_done_ff <= trig_done_ff + 20'h00001;
            if (last_trig)
            begin
              state_ff <= ST_IDLE;
              armed_ff <= 1'b0;
            end
            else
              state_ff <= ST_WAIT;
          end
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // reading-count tracker; memory itself lives beside the converter
  always @(posedge aclk)
  begin
    if (!aresetn || cmd_preset)
    begin
      rd_cnt_ff <= 10'h000;
      ovfl_ff   <= 1'b0;
    end
    else if (cmd_arm & (state_ff == ST_IDLE))
    begin
      rd_cnt_ff <= 10'h000;
      ovfl_ff   <= 1'b0;
    end
    else if ((state_ff == ST_MEAS) & meas_done)
    begin
      if (rd_cnt_ff == `MTSEQ_MEM_DEPTH)
        ovfl_ff <= 1'b1;
      else
        rd_cnt_ff <= rd_cnt_ff + 10'h001;
    end
  end

  // read channel
  reg [31:0] rd_mux;
  reg        rd_hit;
  always @*
  begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `MTSEQ_OFF_CTRL:
        rd_mux = {26'h0000000, 1'b0, inf_ff, auto_ff, pol_rise_ff, src_ff};
      `MTSEQ_OFF_DELAY:   rd_mux = delay_ff;
      `MTSEQ_OFF_SAMPLES: rd_mux = {12'h000, samples_ff};
      `MTSEQ_OFF_TRIGCNT: rd_mux = {12'h000, trigcnt_ff};
      `MTSEQ_OFF_COMMAND: rd_mux = 32'h00000000;
      `MTSEQ_OFF_STATUS:
        rd_mux = {17'h00000, ovfl_ff, 11'h000, pend_ff, busy_ff,
                  armed_ff};
      `MTSEQ_OFF_RDCOUNT: rd_mux = {22'h000000, rd_cnt_ff};
      `MTSEQ_OFF_AUTODLY: rd_mux = eff_delay;
      default:
      begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `MTSEQ_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? `MTSEQ_RESP_OKAY : `MTSEQ_RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // mtseq_top
`default_nettype wire

// *** shared/mtseq_defines.vh ***
// constants for the measurement trigger sequencer
`ifndef MTSEQ_DEFINES_VH
`define MTSEQ_DEFINES_VH
// register byte offsets
`define MTSEQ_OFF_CTRL     8'h00
`define MTSEQ_OFF_DELAY    8'h04
`define MTSEQ_OFF_SAMPLES  8'h08
`define MTSEQ_OFF_TRIGCNT  8'h0C
`define MTSEQ_OFF_COMMAND  8'h10
`define MTSEQ_OFF_STATUS   8'h14
`define MTSEQ_OFF_RDCOUNT  8'h18
`define MTSEQ_OFF_AUTODLY  8'h1C
// ctrl fields
`define MTSEQ_CTRL_SRC_LO  0
`define MTSEQ_CTRL_SRC_HI  1
`define MTSEQ_CTRL_POL     2
`define MTSEQ_CTRL_AUTO    3
`define MTSEQ_CTRL_INF     4
`define MTSEQ_CTRL_CONT    5
// trigger sources
`define MTSEQ_SRC_IMM      2'h0
`define MTSEQ_SRC_BUS      2'h1
`define MTSEQ_SRC_EXT      2'h2
// command bits
`define MTSEQ_CMD_ARM      0
`define MTSEQ_CMD_TRG      1
`define MTSEQ_CMD_ABORT    2
`define MTSEQ_CMD_PRESET   3
// status bits
`define MTSEQ_ST_ARMED     0
`define MTSEQ_ST_BUSY      1
`define MTSEQ_ST_PEND      2
`define MTSEQ_ST_OVFL      14
// defaults
`define MTSEQ_DLY_DEFAULT  32'h000F4240
`define MTSEQ_DLY_MAX      32'hD693A400
`define MTSEQ_CNT_DEFAULT  20'h00001
`define MTSEQ_TRIG_MAX     20'hF4240
`define MTSEQ_MEM_DEPTH    10'h3E8
// timing: one delay step is 1 us at 25 MHz
`define MTSEQ_STEP_NS      1000
`define MTSEQ_CLK_NS       40
`define MTSEQ_RESP_OKAY    2'h0
`define MTSEQ_RESP_SLVERR  2'h2
`endif

// *** tb/mtseq_partner.sv ***
// converter and external trigger source model
`default_nettype none
module mtseq_partner (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // converter side
  input  wire logic meas_start_ff,
  input  wire logic slow,
  output logic      meas_done,
  // external trigger source
  input  wire logic pol_rise,
  input  wire logic fire,
  output logic      ext_trig_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] conv_ff;
  logic [3:0] pulse_ff;
  // done only answers a start, promptly or after a stall
  always @(posedge aclk)
  begin
    meas_done <= 1'b0;
    if (!aresetn)
      conv_ff <= 4'h0;
    else if (meas_start_ff)
      conv_ff <= slow ? 4'h9 : 4'h1;
    else if (conv_ff != 4'h0)
    begin
      conv_ff <= conv_ff - 4'h1;
      meas_done <= (conv_ff == 4'h1);
    end
  end
  always @(posedge aclk)
    if (!aresetn || fire)
      pulse_ff <= aresetn ? 4'h4 : 4'h0;
    else if (pulse_ff != 4'h0)
      pulse_ff <= pulse_ff - 4'h1;
  // idle on the non-qualifying level, so only the leading edge counts
  assign ext_trig_in = (pulse_ff != 4'h0) ~^ pol_rise;
endmodule // mtseq_partner
`default_nettype wire

// *** tb/mtseq_properties.sv ***
// port checker for the trigger sequencer
`default_nettype none
module mtseq_properties (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // sequencer
  input wire logic        meas_start_ff,
  input wire logic        meas_done,
  input wire logic        armed_ff,
  input wire logic        busy_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic pend_ff;
  logic nxt_pend;
  // open conversion: a start with no done yet
  always_comb nxt_pend = meas_start_ff | (pend_ff & ~meas_done);
  always_ff @(posedge aclk)
    pend_ff <= aresetn & nxt_pend;
  sequence seq_start;
    meas_start_ff;
  endsequence
  sequence seq_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence seq_wr_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  AST_START_PULSE: assert property (seq_start |=> !meas_start_ff)
    else $error("start request wider than one cycle");
  AST_START_BUSY: assert property (seq_start |-> busy_ff)
    else $error("start request outside a burst");
  AST_ONE_OPEN: assert property (seq_start |-> !pend_ff)
    else $error("start request before previous completion");
  AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready wider than one cycle");
  AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready wider than one cycle");
  AST_RD_ANSWER: assert property (seq_rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  AST_WR_ANSWER: assert property (seq_wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  AST_RST_CLEAR: assert property (disable iff (1'b0)
    !aresetn |=> !armed_ff && !busy_ff && !meas_start_ff)
    else $error("sequencer outputs not cleared by reset");
endmodule // mtseq_properties
bind mtseq_top mtseq_properties u_chk (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .meas_start_ff, .meas_done, .armed_ff, .busy_ff);
`default_nettype wire

// *** tb/test_measurement_trigger_sequencer.sv ***
// self-checking bench for the trigger sequencer
`include "mtseq_defines.vh"
`default_nettype none
module test_measurement_trigger_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 2;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, ext_trig_in;
  logic        meas_start_ff, meas_done, func_cont_diode, armed_ff;
  logic        busy_ff, slow, pol_rise, fire;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, auto_delay_us, seed, rd, rs, bs;
  int          err_count, checks_done, n_start, cyc, last_st, min_gap, d;
  mtseq_top #(.CLK_DIV(DIV)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_trig_in, .meas_start_ff, .meas_done, .func_cont_diode,
    .auto_delay_us, .armed_ff, .busy_ff);
  mtseq_partner u_far (.aclk, .aresetn, .meas_start_ff, .slow,
    .meas_done, .pol_rise, .fire, .ext_trig_in);
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic [31:0] exp_ctrl(input logic [1:0] src, input logic p, a);
    return {28'h0, a, p, src};
  endfunction
  function int exp_meas(input int s, input int t);
    return (s == 0 ? 1 : s) * t;
  endfunction
  task automatic conclude();
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    // late bready makes the response wait a cycle
    s_axi_bready <= 1'b1;
    do
      @(posedge aclk);
    while (s_axi_bvalid !== 1'b1);
    bs = {30'h0, s_axi_bresp};
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    do
      @(posedge aclk);
    while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = {30'h0, s_axi_rresp};
    s_axi_rready <= 1'b0;
    chk($sformatf("reg %h", a), rd, e);
  endtask
  task automatic go(input int s, input int t);
    axi_wr(`MTSEQ_OFF_SAMPLES, s);
    axi_wr(`MTSEQ_OFF_TRIGCNT, t);
    n_start = 0;
    min_gap = 32'h7FFF;
    last_st = cyc;
    axi_wr(`MTSEQ_OFF_COMMAND, 32'h1 << `MTSEQ_CMD_ARM);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 8000 && (armed_ff !== 1'b0 || busy_ff !== 1'b0); k++)
      @(posedge aclk);
    repeat (4) @(posedge aclk);
  endtask
  task automatic pulse_ext();
    @(posedge aclk);
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (10) @(posedge aclk);
  endtask
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (meas_start_ff === 1'b1)
    begin
      n_start <= n_start + 1;
      if (cyc - last_st < min_gap) min_gap <= cyc - last_st;
      last_st <= cyc;
    end
    if (cyc > 60000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
      s_axi_rready, func_cont_diode, slow, pol_rise, fire} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {err_count, checks_done, n_start, cyc, last_st, min_gap} = '0;
    s_axi_wstrb = 4'hF;
    auto_delay_us = 32'h3;
    seed = 32'h041D;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`MTSEQ_OFF_CTRL, exp_ctrl(`MTSEQ_SRC_IMM, 1'b0, 1'b1));
    rd_chk(`MTSEQ_OFF_DELAY, `MTSEQ_DLY_DEFAULT);
    rd_chk(`MTSEQ_OFF_AUTODLY, auto_delay_us);
    rd_chk(8'h40, 32'h0);
    chk("unmapped resp", rs, {30'h0, `MTSEQ_RESP_SLVERR});
    axi_wr(8'h40, 32'h1);
    chk("unmapped wr resp", bs, {30'h0, `MTSEQ_RESP_SLVERR});
    repeat (4)
    begin
      seed = lfsr(seed);
      d = seed[1:0] + 1;
      slow <= seed[6];
      axi_wr(`MTSEQ_OFF_CTRL, exp_ctrl(`MTSEQ_SRC_IMM, 1'b0, 1'b1));
      axi_wr(`MTSEQ_OFF_DELAY, d);
      chk("wr resp", bs, {30'h0, `MTSEQ_RESP_OKAY});
      rd_chk(`MTSEQ_OFF_CTRL, exp_ctrl(`MTSEQ_SRC_IMM, 1'b0, 1'b0));
      rd_chk(`MTSEQ_OFF_AUTODLY, d);
      chk("rd resp", rs, {30'h0, `MTSEQ_RESP_OKAY});
      go(seed[3:2] + 1, seed[5:4] + 1);
      wait_idle();
      chk("starts", n_start, exp_meas(seed[3:2] + 1, seed[5:4] + 1));
      chk("delay gap", min_gap >= (d - 1) * DIV, 1);
    end
    func_cont_diode <= 1'b1;
    axi_wr(`MTSEQ_OFF_DELAY, 32'd200);
    go(0, 1);
    wait_idle();
    chk("test start", n_start, exp_meas(0, 1));
    chk("no delay", min_gap < 20, 1);
    func_cont_diode <= 1'b0;
    axi_wr(`MTSEQ_OFF_CTRL, exp_ctrl(`MTSEQ_SRC_BUS, 1'b0, 1'b0));
    n_start = 0;
    axi_wr(`MTSEQ_OFF_COMMAND, 32'h1 << `MTSEQ_CMD_TRG);
    repeat (20) @(posedge aclk);
    chk("bus unarmed", n_start, 0);
    go(2, 1);
    repeat (40) @(posedge aclk);
    chk("bus waiting", n_start, 0);
    chk("armed", armed_ff, 1);
    chk("idle busy", busy_ff, 0);
    rd_chk(`MTSEQ_OFF_STATUS, 32'h1 << `MTSEQ_ST_ARMED);
    axi_wr(`MTSEQ_OFF_COMMAND, 32'h1 << `MTSEQ_CMD_TRG);
    chk("burst busy", busy_ff, 1);
    wait_idle();
    chk("bus burst", n_start, exp_meas(2, 1));
    rd_chk(`MTSEQ_OFF_RDCOUNT, 32'h2);
    rd_chk(`MTSEQ_OFF_STATUS, 32'h0);
    for (int p = 0; p < 2; p++)
    begin
      pol_rise <= p[0];
      axi_wr(`MTSEQ_OFF_CTRL, exp_ctrl(`MTSEQ_SRC_EXT, p[0], 1'b0));
      axi_wr(`MTSEQ_OFF_DELAY, 32'h3);
      n_start = 0;
      pulse_ext();
      repeat (20) @(posedge aclk);
      chk("ext unarmed", n_start, 0);
      go(2, 2);
      pulse_ext();
      pulse_ext();
      wait_idle();
      chk("ext bursts", n_start, exp_meas(2, 2));
    end
    // one reading more than the memory holds, at the quickest pace
    axi_wr(`MTSEQ_OFF_CTRL, exp_ctrl(`MTSEQ_SRC_IMM, 1'b0, 1'b0));
    axi_wr(`MTSEQ_OFF_DELAY, 32'h0);
    slow <= 1'b0;
    go(`MTSEQ_MEM_DEPTH + 1, 1);
    wait_idle();
    chk("full starts", n_start, exp_meas(`MTSEQ_MEM_DEPTH + 1, 1));
    rd_chk(`MTSEQ_OFF_RDCOUNT, `MTSEQ_MEM_DEPTH);
    rd_chk(`MTSEQ_OFF_STATUS, 32'h1 << `MTSEQ_ST_OVFL);
    axi_wr(`MTSEQ_OFF_COMMAND, 32'h1 << `MTSEQ_CMD_PRESET);
    rd_chk(`MTSEQ_OFF_STATUS, 32'h0);
    rd_chk(`MTSEQ_OFF_CTRL, exp_ctrl(`MTSEQ_SRC_IMM, 1'b0, 1'b1));
    conclude();
  end
endmodule // test_measurement_trigger_sequencer
`default_nettype wire
